/* rbp_pkg.sv */
// Constants, register map and carrier types of the receive backplane port.
// Assumes a single 250 MHz APB clock shared with the framer core.
// Summary of operation
// - Serial data leaves as NRZ, on line clock rising edges without elastic store or interleaved backplane.
// - With elastic store or interleaved backplane, data moves on backplane clock.
// - Recovered line clock, 1.544 or 2.048 MHz, is driven out as a pin.
// - Sync pin as input with store: system pulses boundary, port aligns to it.
// - T1 frame pulses on sync pin may widen to two periods on signaling frames.
// - In E1 the sync output can mark CAS or CRC-4 multiframes.
// - Sync pin is an input after reset; direction is bit 2 of receive I/O config.
// - Frame pulse mode gives an 8 kHz pulse one line period wide per frame.
// - Multiframe pulse is one line period, or one backplane period with store.
// - In E1 without store the multiframe pulse marks CRC-4 or CAS, chosen by config bit 1.
// - Signaling bits leave in PCM form, timed like the serial data.
// - First alarm pin shows analog loss, framer loss or freeze, per global config.
// - Framer loss selection goes high on framer loss or on signaling freeze.
// - Frame loss selection of second alarm is high while the synchronizer searches.
// - Clock loss selection goes high after about three missing transmit clock periods.
// - Sync input accepts an H.100 style frame sync pulse.
package rbp_pkg;

  localparam int unsigned CLK_PERIOD_PS = 4000;

  // Three periods of the slowest transmit line clock, 1.544 MHz
  localparam int unsigned XCLK_LOSS_NS = 1943;
  localparam int unsigned XCLK_LOSS_CYC = (XCLK_LOSS_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned XCLK_CNT_W = 10;

  // Register byte offsets
  localparam logic [7:0] REG_RECV_IO_CONFIG = 8'h00;
  localparam logic [7:0] REG_GLOBAL_CLOCK_CONFIG = 8'h04;
  localparam logic [7:0] REG_PORT_CONTROL = 8'h08;
  localparam logic [7:0] REG_PORT_STATUS = 8'h0c;

  // Receive I/O config fields
  localparam int unsigned BIT_E1_MULTIFRAME_SEL = 1;
  localparam int unsigned BIT_SYNC_DIRECTION_SEL = 2;
  localparam int unsigned BIT_SYNC_WIDE = 3;
  localparam logic [3:0] RECV_IO_CONFIG_RST = 4'h0;

  // Global clock config fields: first alarm pin source
  localparam int unsigned ALARM1_LSB = 0;
  localparam logic [1:0] ALARM1_ANALOG = 2'h0;
  localparam logic [1:0] ALARM1_FRAMER = 2'h1;
  localparam logic [1:0] ALARM1_FREEZE = 2'h2;
  localparam logic [1:0] GLOBAL_CLOCK_CONFIG_RST = 2'h0;

  // Port control fields
  localparam int unsigned BIT_ELASTIC_EN = 0;
  localparam int unsigned BIT_INTERLEAVED = 1;
  localparam int unsigned BIT_E1_MODE = 2;
  localparam int unsigned BIT_MULTIFRAME_MODE = 3;
  localparam int unsigned BIT_ALARM2_CLOCK = 4;
  localparam logic [4:0] PORT_CONTROL_RST = 5'h00;

  // Port status fields
  localparam int unsigned BIT_ST_SYNC_PIN = 0;
  localparam int unsigned BIT_ST_ANALOG_LOSS = 1;
  localparam int unsigned BIT_ST_XCLK_LOSS = 2;
  localparam int unsigned BIT_ST_SEARCHING = 3;

  // Framer side, valid on each line clock tick
  typedef struct packed {
    logic data_bit;
    logic sig_bit;
    logic frame_start;
    logic sig_frame;
    logic mf_cas;
    logic mf_crc4;
  } rbp_line_t;

  // Elastic store side, valid on each backplane clock tick
  typedef struct packed {
    logic data_bit;
    logic sig_bit;
    logic mf_start;
  } rbp_sys_t;

  // Framer state flags
  typedef struct packed {
    logic framer_los;
    logic sig_freeze;
    logic searching;
  } rbp_alarm_t;

endpackage

/* rbp_port.sv */
// Receive backplane port: output timing, sync pin, alarm pins, APB registers.
// Framer, elastic store and alarm flags arrive on pclk; clock pins and the
// analog loss flag are asynchronous and pass two flip-flops first.
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/10ps
module rbp_port
  import rbp_pkg::*;
(
  input wire logic pclk, // 250 MHz system clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic line_clock_pin, // Recovered clock from line front end
  input wire logic recv_backplane_clock, // System backplane clock pin
  input wire logic xmit_line_clock, // Transmit line clock pin
  input wire logic analog_loss_pin, // Loss flag from line front end
  input wire rbp_line_t line_in, // Framer outputs
  input wire rbp_sys_t sys_in, // Elastic store outputs
  input wire rbp_alarm_t alarm_in, // Framer state flags
  output logic line_tick, // Line clock rising edge, one cycle
  output logic sys_tick, // Backplane clock rising edge, one cycle
  output logic sys_align, // Backplane alignment request, held until the next backplane tick
  output logic recv_line_clock, // Recovered line clock out
  output logic recv_serial_out, // NRZ receive data
  output logic recv_signaling_out, // PCM signaling bits
  output logic recv_frame_pulse, // Frame or multiframe pulse
  input wire logic recv_sync_io_i, // Sync pin level
  output logic recv_sync_io_o, // Sync pin drive value
  output logic recv_sync_io_oe, // Sync pin drive enable
  output logic alarm1_ind, // Analog, framer loss or freeze
  output logic alarm2_ind // Frame loss or transmit clock loss
);

  logic [3:0] recv_io_config_q;
  logic [1:0] global_clock_config_q;
  logic [4:0] port_control_q;
  logic [2:0] line_sync_q;
  logic [2:0] sys_sync_q;
  logic [2:0] xclk_sync_q;
  logic [1:0] sync_pin_q;
  logic sync_pin_prev_q;
  logic [1:0] aloss_q;
  logic line_tick_q;
  logic sys_tick_q;
  logic sys_align_q;
  logic line_clock_q;
  logic serial_q;
  logic signaling_q;
  logic frame_pulse_q;
  logic sync_o_q;
  logic sync_oe_q;
  logic wide_pend_q;
  logic alarm1_q;
  logic alarm2_q;
  logic xclk_loss_q;
  logic [XCLK_CNT_W-1:0] xclk_cnt_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  logic elastic_en;
  logic sys_timed;
  logic e1_mode;
  logic mf_mode;
  logic line_mf;
  logic line_rise;
  logic sys_rise;
  logic xclk_edge;
  logic sync_out_dir;
  logic setup_ph;
  logic wr_access;
  logic [31:0] rd_word;
  logic rd_hit;

  assign elastic_en = port_control_q[BIT_ELASTIC_EN];
  assign sys_timed = elastic_en | port_control_q[BIT_INTERLEAVED];
  assign e1_mode = port_control_q[BIT_E1_MODE];
  assign mf_mode = port_control_q[BIT_MULTIFRAME_MODE];
  assign sync_out_dir = recv_io_config_q[BIT_SYNC_DIRECTION_SEL];
  assign line_mf = e1_mode ?
    (recv_io_config_q[BIT_E1_MULTIFRAME_SEL] ? line_in.mf_cas :
     line_in.mf_crc4) : line_in.mf_cas;

  // Pin synchronisers; only stage 1 onward feeds logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_sync_q <= 3'h0;
      sys_sync_q <= 3'h0;
      xclk_sync_q <= 3'h0;
      sync_pin_q <= 2'h0;
      sync_pin_prev_q <= 1'b0;
      aloss_q <= 2'h0;
    end else begin
      line_sync_q <= {line_sync_q[1:0], line_clock_pin};
      sys_sync_q <= {sys_sync_q[1:0], recv_backplane_clock};
      xclk_sync_q <= {xclk_sync_q[1:0], xmit_line_clock};
      sync_pin_q <= {sync_pin_q[0], recv_sync_io_i};
      sync_pin_prev_q <= sync_pin_q[1];
      aloss_q <= {aloss_q[0], analog_loss_pin};
    end
  end

  assign line_rise = line_sync_q[1] & ~line_sync_q[2];
  assign sys_rise = sys_sync_q[1] & ~sys_sync_q[2];
  assign xclk_edge = xclk_sync_q[1] ^ xclk_sync_q[2];

  // Tick strobes and the line clock echo
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_tick_q <= 1'b0;
      sys_tick_q <= 1'b0;
      line_clock_q <= 1'b0;
    end else begin
      line_tick_q <= line_rise;
      sys_tick_q <= sys_rise;
      line_clock_q <= line_sync_q[1];
    end
  end

  // Data and signaling, timed by the line or the backplane clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_q <= 1'b0;
      signaling_q <= 1'b0;
    end else if (sys_timed) begin
      if (sys_rise) begin
        serial_q <= sys_in.data_bit;
        signaling_q <= sys_in.sig_bit;
      end
    end else if (line_rise) begin
      serial_q <= line_in.data_bit;
      signaling_q <= line_in.sig_bit;
    end
  end

  // Frame or multiframe pulse; it lasts until the next tick of its clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_pulse_q <= 1'b0;
    end else if (mf_mode && elastic_en) begin
      if (sys_rise) begin
        frame_pulse_q <= sys_in.mf_start;
      end
    end else if (line_rise) begin
      frame_pulse_q <= mf_mode ? line_mf : line_in.frame_start;
    end
  end

  // Sync pin: input unless the direction bit is set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_oe_q <= 1'b0;
      sync_o_q <= 1'b0;
      wide_pend_q <= 1'b0;
    end else begin
      sync_oe_q <= sync_out_dir;
      if (!sync_out_dir) begin
        sync_o_q <= 1'b0;
        wide_pend_q <= 1'b0;
      end else if (mf_mode && elastic_en) begin
        wide_pend_q <= 1'b0;
        if (sys_rise) begin
          sync_o_q <= sys_in.mf_start;
        end
      end else if (line_rise) begin
        if (mf_mode) begin
          sync_o_q <= line_mf;
          wide_pend_q <= 1'b0;
        end else if (line_in.frame_start) begin
          sync_o_q <= 1'b1;
          // Second period only on T1 signaling frames
          wide_pend_q <= recv_io_config_q[BIT_SYNC_WIDE] & ~e1_mode &
                         line_in.sig_frame;
        end else begin
          sync_o_q <= wide_pend_q;
          wide_pend_q <= 1'b0;
        end
      end
    end
  end

  // Boundary pulse in from the system: rising edge sets the request, next backplane tick clears it.
  // A level-style H.100 strobe works too since only its edge is used.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_align_q <= 1'b0;
    end else if (!sync_out_dir && elastic_en) begin
      if (sync_pin_q[1] && !sync_pin_prev_q) begin
        sys_align_q <= 1'b1;
      end else if (sys_tick_q) begin
        sys_align_q <= 1'b0;
      end
    end else begin
      sys_align_q <= 1'b0;
    end
  end

  // Transmit clock watchdog counts pclk cycles between edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xclk_cnt_q <= '0;
      xclk_loss_q <= 1'b0;
    end else if (xclk_edge) begin
      xclk_cnt_q <= '0;
      xclk_loss_q <= 1'b0;
    end else if (xclk_cnt_q >= XCLK_CNT_W'(XCLK_LOSS_CYC)) begin
      xclk_loss_q <= 1'b1;
    end else begin
      xclk_cnt_q <= xclk_cnt_q + 1'b1;
    end
  end

  // Alarm pins re-registered so a select change cannot glitch them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm1_q <= 1'b0;
      alarm2_q <= 1'b0;
    end else begin
      case (global_clock_config_q)
        ALARM1_ANALOG: alarm1_q <= aloss_q[1];
        ALARM1_FRAMER: begin
          alarm1_q <= alarm_in.framer_los | alarm_in.sig_freeze;
        end
        ALARM1_FREEZE: alarm1_q <= alarm_in.sig_freeze;
        default: alarm1_q <= 1'b0;
      endcase
      if (port_control_q[BIT_ALARM2_CLOCK]) begin
        alarm2_q <= xclk_loss_q;
      end else begin
        alarm2_q <= alarm_in.searching;
      end
    end
  end

  // APB slave: one setup cycle, then access with pready already high
  assign setup_ph = psel & ~penable;
  assign wr_access = psel & penable & pwrite & pready_q & ~pslverr_q;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    if (paddr == REG_RECV_IO_CONFIG) begin
      rd_word[3:0] = recv_io_config_q;
    end else if (paddr == REG_GLOBAL_CLOCK_CONFIG) begin
      rd_word[1:0] = global_clock_config_q;
    end else if (paddr == REG_PORT_CONTROL) begin
      rd_word[4:0] = port_control_q;
    end else if (paddr == REG_PORT_STATUS) begin
      rd_word[BIT_ST_SYNC_PIN] = sync_pin_q[1];
      rd_word[BIT_ST_ANALOG_LOSS] = aloss_q[1];
      rd_word[BIT_ST_XCLK_LOSS] = xclk_loss_q;
      rd_word[BIT_ST_SEARCHING] = alarm_in.searching;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= setup_ph;
      pslverr_q <= setup_ph & ~rd_hit;
      if (setup_ph && !pwrite) begin
        prdata_q <= rd_word;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recv_io_config_q <= RECV_IO_CONFIG_RST;
      global_clock_config_q <= GLOBAL_CLOCK_CONFIG_RST;
      port_control_q <= PORT_CONTROL_RST;
    end else if (wr_access) begin
      if (paddr == REG_RECV_IO_CONFIG) begin
        recv_io_config_q <= pwdata[3:0];
      end else if (paddr == REG_GLOBAL_CLOCK_CONFIG) begin
        global_clock_config_q <= pwdata[1:0];
      end else if (paddr == REG_PORT_CONTROL) begin
        port_control_q <= pwdata[4:0];
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign line_tick = line_tick_q;
  assign sys_tick = sys_tick_q;
  assign sys_align = sys_align_q;
  assign recv_line_clock = line_clock_q;
  assign recv_serial_out = serial_q;
  assign recv_signaling_out = signaling_q;
  assign recv_frame_pulse = frame_pulse_q;
  assign recv_sync_io_o = sync_o_q;
  assign recv_sync_io_oe = sync_oe_q;
  assign alarm1_ind = alarm1_q;
  assign alarm2_ind = alarm2_q;

endmodule

/* rbp_bp_partner.sv */
// Backplane partner: backplane clock source and sync pin driver.
// Assumes the bench resolves the sync wire from the port's drive enable.
`timescale 1ns/10ps
module rbp_bp_partner (
  input wire logic pclk, // Bench clock
  input wire logic clk_en, // Store or interleaved in use
  input wire logic pulse_req, // Boundary pulse request
  input wire logic sync_oe, // Port drives sync pin
  output logic bp_clock, // Backplane clock
  output logic sync_drv // Our sync pin level
);
  logic [2:0] div_q = 3'h0;
  logic clk_q = 1'b0;
  logic sync_q = 1'b0;
  always_ff @(posedge pclk) begin
    div_q <= div_q + 3'h1;
    clk_q <= clk_en & div_q[2]; // Held low while unused
  end
  // Idle pin rests low, so no stale pulse is seen
  always_ff @(posedge pclk) begin
    sync_q <= !sync_oe && pulse_req;
  end
  assign bp_clock = clk_q;
  assign sync_drv = sync_q;
endmodule

/* rbp_port_sva.sv */
// Checker for the receive backplane port, bound into every rbp_port.
// Shadows the configuration bits it needs from APB writes.
`timescale 1ns/10ps
module rbp_port_chk
  import rbp_pkg::*;
(
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic pready, // APB ready
  input wire logic line_clock_pin, // Line clock pin
  input wire logic xmit_line_clock, // Transmit clock pin
  input wire rbp_alarm_t alarm_in, // Framer flags
  input wire logic line_tick, // Line tick
  input wire logic sys_tick, // Backplane tick
  input wire logic sys_align, // Alignment request
  input wire logic recv_serial_out, // Serial data
  input wire logic recv_signaling_out, // Signaling
  input wire logic recv_frame_pulse, // Frame pulse
  input wire logic recv_sync_io_i, // Sync pin level
  input wire logic recv_sync_io_oe, // Sync drive enable
  input wire logic alarm1_ind, // First alarm
  input wire logic alarm2_ind // Second alarm
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic io_q;
  logic ctl_q;
  logic [1:0] gsel_q;
  wire wr = psel && penable && pwrite && pready;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_q <= 1'b0;
      gsel_q <= 2'h0;
      ctl_q <= 1'b0;
    end else if (wr) begin
      if (paddr == REG_RECV_IO_CONFIG) io_q <= pwdata[2];
      if (paddr == REG_GLOBAL_CLOCK_CONFIG) gsel_q <= pwdata[1:0];
      if (paddr == REG_PORT_CONTROL) ctl_q <= pwdata[4];
    end
  end
  sequence s_tick;
    line_tick ##1 !line_tick;
  endsequence
  property p_tick;
    $rose(line_clock_pin) |-> ##[1:5] s_tick;
  endproperty
  a_tick: assert property (p_tick)
    else $error("line tick missing");
  property p_data;
    $changed(recv_serial_out) || $changed(recv_signaling_out) ||
      $changed(recv_frame_pulse) |-> line_tick || sys_tick;
  endproperty
  a_data: assert property (p_data)
    else $error("output moved off a tick");
  property p_dir;
    io_q == $past(io_q) && io_q == $past(io_q, 2) |->
      recv_sync_io_oe == io_q;
  endproperty
  a_dir: assert property (p_dir)
    else $error("sync direction wrong");
  property p_frz;
    gsel_q == ALARM1_FREEZE && $stable(gsel_q) |->
      alarm1_ind == $past(alarm_in.sig_freeze);
  endproperty
  a_frz: assert property (p_frz)
    else $error("freeze alarm wrong");
  property p_framer_loss_ind;
    gsel_q == ALARM1_FRAMER && $stable(gsel_q) |->
      alarm1_ind == ($past(alarm_in.framer_los) | $past(alarm_in.sig_freeze));
  endproperty
  a_framer_loss_ind: assert property (p_framer_loss_ind)
    else $error("framer loss alarm wrong");
  property p_srch;
    !ctl_q && $stable(ctl_q) |-> alarm2_ind == $past(alarm_in.searching);
  endproperty
  a_srch: assert property (p_srch)
    else $error("frame loss alarm wrong");
  property p_xclk;
    ctl_q && $changed(xmit_line_clock) |-> ##[1:8] !alarm2_ind;
  endproperty
  a_xclk: assert property (p_xclk)
    else $error("clock loss not cleared");
  property p_align;
    // A new pin edge on the tick cycle wins over the clear
    sys_tick && !($past(recv_sync_io_i, 2) && !$past(recv_sync_io_i, 3))
      |=> !sys_align;
  endproperty
  a_align: assert property (p_align)
    else $error("alignment not cleared");
endmodule

bind rbp_port rbp_port_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .line_clock_pin, .xmit_line_clock, .alarm_in,
  .line_tick, .sys_tick, .sys_align, .recv_serial_out, .recv_signaling_out,
  .recv_frame_pulse, .recv_sync_io_i, .recv_sync_io_oe, .alarm1_ind,
  .alarm2_ind);

/* tb_top.sv */
// Testbench for the receive backplane port with a backplane partner.
// Line and transmit clocks are scaled down and derived from pclk.
`timescale 1ns/10ps
module tb_top;
  import rbp_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, xrun = 1'b1, bp_en = 1'b0, preq = 1'b0, err;
  logic line_clock_pin = 1'b0, xmit_line_clock = 1'b0, analog_loss_pin = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, line_tick, sys_tick, sys_align, recv_line_clock;
  logic recv_serial_out, recv_signaling_out, recv_frame_pulse, sync_o;
  logic sync_oe, sync_drv, sync_wire, bp_clock, alarm1_ind, alarm2_ind;
  logic [4:0] cnt_q = 5'h00;
  rbp_line_t line_in = '0;
  rbp_sys_t sys_in = '0;
  rbp_alarm_t alarm_in = '0;
  int n_errors = 0, n_checks = 0;
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cnt_q <= cnt_q + 5'h1;
    line_clock_pin <= ~cnt_q[4];
    xmit_line_clock <= xrun ? cnt_q[2] : xmit_line_clock;
  end
  assign sync_wire = sync_oe ? sync_o : sync_drv;
  rbp_port DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .line_clock_pin,
    .recv_backplane_clock(bp_clock), .xmit_line_clock, .analog_loss_pin,
    .line_in, .sys_in, .alarm_in, .line_tick, .sys_tick, .sys_align,
    .recv_line_clock, .recv_serial_out, .recv_signaling_out,
    .recv_frame_pulse, .recv_sync_io_i(sync_wire), .recv_sync_io_o(sync_o),
    .recv_sync_io_oe(sync_oe), .alarm1_ind, .alarm2_ind);
  rbp_bp_partner u_bp (.pclk, .clk_en(bp_en), .pulse_req(preq), .sync_oe,
    .bp_clock, .sync_drv);

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      chk(1'b0, 1'b1);
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll after the edge so the tick edge updates have landed
  task automatic wt(input bit s);
    for (int k = 0; k < 300; k++) begin
      @(posedge pclk);
      #1;
      if ((s ? sys_tick : line_tick) === 1'b1) return;
    end
    n_errors++;
    stop_test();
  endtask
  // Leading tick keeps the new fields clear of the sampling edge
  task automatic send(input bit s, input rbp_line_t lv, input rbp_sys_t sv);
    wt(s);
    @(posedge pclk);
    line_in <= lv;
    sys_in <= sv;
    wt(s);
  endtask

  task automatic t_regs();
    apb(1'b0, REG_RECV_IO_CONFIG, 32'h0);
    chk(rd, 32'h0);
    chk(sync_oe, 1'b0);
    apb(1'b1, REG_RECV_IO_CONFIG, 32'h0000000e);
    apb(1'b0, REG_RECV_IO_CONFIG, 32'h0);
    chk(rd, 32'h0000000e);
    apb(1'b1, 8'h10, 32'hffffffff);
    chk(err, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_line();
    apb(1'b1, REG_RECV_IO_CONFIG, 32'h0);
    apb(1'b1, REG_PORT_CONTROL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      send(1'b0, '{data_bit: i[0], sig_bit: i[1], default: 1'b0}, '0);
      chk(recv_serial_out, i[0]);
      chk(recv_signaling_out, i[1]);
      chk(recv_line_clock, 1'b1);
    end
    send(1'b0, '{frame_start: 1'b1, default: 1'b0}, '0);
    chk(recv_frame_pulse, 1'b1);
    send(1'b0, '0, '0);
    chk(recv_frame_pulse, 1'b0);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, REG_RECV_IO_CONFIG, {30'h0, i[0], 1'b0});
      apb(1'b1, REG_PORT_CONTROL, i[1] ? 32'h08 : 32'h0c);
      send(1'b0, '{mf_cas: 1'b1, default: 1'b0}, '0);
      chk(recv_frame_pulse, i != 0);
      send(1'b0, '0, '0);
      chk(recv_frame_pulse, 1'b0);
    end
  endtask
  task automatic t_wide();
    apb(1'b1, REG_PORT_CONTROL, 32'h0);
    apb(1'b1, REG_RECV_IO_CONFIG, 32'h0000000c);
    for (int w = 0; w < 2; w++) begin
      send(1'b0, '{frame_start: 1'b1, sig_frame: w[0], default: 1'b0}, '0);
      chk({sync_oe, sync_o}, 2'b11);
      @(posedge pclk);
      line_in <= '0;
      wt(1'b0);
      chk(sync_o, w[0]);
      wt(1'b0);
      chk(sync_o, 1'b0);
    end
    apb(1'b1, REG_PORT_CONTROL, 32'h0c);
    apb(1'b1, REG_RECV_IO_CONFIG, 32'h00000006);
    send(1'b0, '{mf_cas: 1'b1, default: 1'b0}, '0);
    chk(sync_o, 1'b1);
  endtask
  task automatic t_alarm();
    logic e;
    apb(1'b1, REG_PORT_CONTROL, 32'h0);
    for (int p = 0; p < 3; p++) begin
      analog_loss_pin <= (p == 0);
      alarm_in <= '{framer_los: p == 2, sig_freeze: p == 1, searching: p == 1};
      for (int s = 0; s < 4; s++) begin
        apb(1'b1, REG_GLOBAL_CLOCK_CONFIG, 32'(s));
        repeat (4) @(posedge pclk);
        e = (s == 0) ? (p == 0) : (s == 1) ? (p != 0) : (s == 2 && p == 1);
        chk(alarm1_ind, e);
        chk(alarm2_ind, p == 1);
      end
      apb(1'b0, REG_PORT_STATUS, 32'h0);
      chk(rd[BIT_ST_ANALOG_LOSS], p == 0);
      chk(rd[BIT_ST_SEARCHING], p == 1);
    end
    alarm_in <= '0;
  endtask
  task automatic t_xclk();
    int k;
    apb(1'b1, REG_PORT_CONTROL, 32'h10);
    repeat (20) @(posedge pclk);
    chk(alarm2_ind, 1'b0);
    xrun <= 1'b0;
    repeat (XCLK_LOSS_CYC - 40) @(posedge pclk);
    chk(alarm2_ind, 1'b0);
    for (k = 0; k < 100 && alarm2_ind !== 1'b1; k++) @(posedge pclk);
    chk(alarm2_ind, 1'b1);
    if (k == 100) stop_test();
    xrun <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(alarm2_ind, 1'b0);
  endtask
  task automatic t_elastic();
    int k;
    bp_en <= 1'b1;
    apb(1'b1, REG_PORT_CONTROL, 32'h09);
    for (int i = 0; i < 4; i++) begin
      send(1'b1, '0, '{data_bit: i[0], sig_bit: i[0], mf_start: i[1]});
      chk(recv_serial_out, i[0]);
      chk(recv_signaling_out, i[0]);
      chk(recv_frame_pulse, i[1]);
    end
    apb(1'b1, REG_PORT_CONTROL, 32'h02);
    send(1'b1, '0, '{data_bit: 1'b1, default: 1'b0});
    chk(recv_serial_out, 1'b1);
    apb(1'b1, REG_PORT_CONTROL, 32'h01);
    apb(1'b1, REG_RECV_IO_CONFIG, 32'h0);
    preq <= 1'b1;
    for (k = 0; k < 40 && sys_align !== 1'b1; k++) @(posedge pclk);
    chk(sys_align, 1'b1);
    if (k == 40) stop_test();
    preq <= 1'b0;
    wt(1'b1);
    @(posedge pclk);
    #1;
    chk(sys_align, 1'b0);
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_line();
    t_wide();
    t_alarm();
    t_xclk();
    t_elastic();
    stop_test();
  end
endmodule
